// *** second_uart_pkg.sv ***
// constants, types and register map of the second serial port
package second_uart_pkg;

  // register byte addresses
  localparam logic [7:0] SCON_ADDR   = 8'hc0;
  localparam logic [7:0] DATA_ADDR   = 8'hc1;
  localparam logic [7:0] CFG_ADDR    = 8'hc2;
  localparam logic [7:0] RELOAD_ADDR = 8'hc3;

  // serial control field positions
  localparam int unsigned SCON_HI  = 7;
  localparam int unsigned SCON_LO  = 6;
  localparam int unsigned SCON_MP  = 5;
  localparam int unsigned SCON_REN = 4;
  localparam int unsigned SCON_TB8 = 3;
  localparam int unsigned SCON_RB8 = 2;
  localparam int unsigned SCON_TI  = 1;
  localparam int unsigned SCON_RI  = 0;

  // configuration field positions
  localparam int unsigned CFG_FSEL = 0;
  localparam int unsigned CFG_DBL  = 1;
  localparam int unsigned CFG_SMOD = 2;
  localparam int unsigned CFG_FULL = 7;

  // reset values
  localparam logic [7:0] SCON_RESET   = 8'h00;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;

  // crystal clocks per bit
  localparam logic [15:0] DIV_SHIFT      = 16'h000c;
  localparam logic [15:0] DIV_SHIFT_FAST = 16'h0006;
  localparam logic [15:0] DIV_FIXED      = 16'h0040;
  localparam logic [15:0] DIV_FIXED_FAST = 16'h0020;
  localparam int unsigned VAR_SHIFT      = 4;

  // buffer geometry
  localparam int unsigned TXBUF_WIDTH = 9;
  localparam int unsigned TXBUF_DEPTH = 2;

  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART8,
    MODE_UART9_FIXED,
    MODE_UART9_VAR
  } mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic       mode_select_high;
    logic       mode_select_low;
    logic       multiproc_enable;
    logic       rx_enable;
    logic       tx_ninth_bit;
    logic       rx_ninth_bit;
    logic       tx_done_flag;
    logic       rx_done_flag;
    logic       framing_error_flag;
    logic       frame_error_access_select;
    logic       double_speed_option;
    logic       double_baud;
    logic [7:0] reload;
    logic [7:0] rx_data;
  } ctrl_s;

endpackage

// *** two_entry_buffer.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module two_entry_buffer
  import second_uart_pkg::*;
#(
  parameter int unsigned WIDTH = TXBUF_WIDTH,
  parameter int unsigned DEPTH = TXBUF_DEPTH
)(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [PW:0]      count_reg, count_next;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push)
    begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next          = bump(wr_ptr_reg);
    end
    if (pop)
      rd_ptr_next = bump(rd_ptr_reg);
    if (push && !pop)
      count_next = count_reg + (PW+1)'(1);
    else if (pop && !push)
      count_next = count_reg - (PW+1)'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
    mem_reg <= mem_next;
  end

endmodule // two_entry_buffer

// *** second_uart.sv ***
// second serial port: control register, transmitter and receiver
//
// What this block does
// RL1 - with access option on, bit 7 is a sticky framing error, software cleared
// RL2 - bit 7 reaches the high mode bit only while access option is off
// RL3 - mode bits pick shift register, 8-bit uart, or two 9-bit uarts with rates
// RL4 - multiprocessor enable in modes 2/3 gates receive completion on address bit
// RL5 - frames are received only while receive enable is set
// RL6 - in modes 2/3 the transmit ninth bit goes out as ninth data bit
// RL7 - in modes 2/3 the received ninth bit loads the receive ninth flag
// RL8 - transmit done set after 8th bit in mode 0, else at stop start
// RL9 - receive done set after 8th bit in mode 0, else at stop sampling
// RL10 - interrupt request stands while either done flag is set
// RL11 - async frame: low start, data lsb first, optional ninth, high stop
`timescale 1ns/1ps
module second_uart
  import second_uart_pkg::*;
(
  // clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst,
  // register port
  input  wire bus_req_s  bus_req,
  output logic [7:0]     rdata,
  // serial pins
  input  wire logic      rxd_in,
  output logic           rxd_out,
  output logic           rxd_oe,
  output logic           txd_out,
  // status
  output logic           tx_buf_ready,
  output logic           uart_irq
);

  typedef enum logic [2:0] {T_IDLE, T_SHIFT, T_START, T_DATA, T_NINTH, T_STOP} tx_state_e;
  typedef enum logic [2:0] {R_IDLE, R_SHIFT, R_START, R_DATA, R_NINTH, R_STOP} rx_state_e;

  ctrl_s            ctrl_reg, ctrl_next;
  logic [7:0]       rdata_reg, rdata_next;
  tx_state_e        tx_state_reg, tx_state_next;
  logic [15:0]      tx_cnt_reg, tx_cnt_next;
  logic [2:0]       tx_idx_reg, tx_idx_next;
  logic [8:0]       tx_shift_reg, tx_shift_next;
  logic             tx_line_reg, tx_line_next;
  logic             tx_oe_reg, tx_oe_next;
  logic             tx_data_reg, tx_data_next;
  rx_state_e        rx_state_reg, rx_state_next;
  logic [15:0]      rx_cnt_reg, rx_cnt_next;
  logic [2:0]       rx_idx_reg, rx_idx_next;
  logic [8:0]       rx_shift_reg, rx_shift_next;
  logic             rx_sclk_reg, rx_sclk_next;
  logic             rx_meta_reg, rx_sync_reg, rx_prev_reg;
  logic             ti_set, ri_set, fe_set;
  logic             rx_load;
  logic [7:0]       rx_load_data;
  logic             rx_load_ninth;
  mode_e            mode;
  logic             mode9;
  logic [15:0]      period;
  logic [15:0]      half;
  logic             buf_in_valid;
  logic             buf_out_valid;
  logic             buf_pop;
  logic [8:0]       buf_out_data;

  // bit period in core clocks for the current mode
  function automatic logic [15:0] bit_cycles(input mode_e m, input logic fast,
                                             input logic smod, input logic [7:0] rl);
    logic [15:0] base;
    case (m)
      MODE_SHIFT:       base = fast ? DIV_SHIFT_FAST : DIV_SHIFT; // RL3
      MODE_UART9_FIXED: base = (smod ? DIV_FIXED_FAST : DIV_FIXED) >> fast; // RL3
      default:          base = (({8'h00, rl} + 16'h0001) << VAR_SHIFT) >> fast; // RL3
    endcase
    return base;
  endfunction

  assign mode   = mode_e'({ctrl_reg.mode_select_high, ctrl_reg.mode_select_low}); // RL3
  assign mode9  = mode[1];
  assign period = bit_cycles(mode, ctrl_reg.double_speed_option, ctrl_reg.double_baud,
                             ctrl_reg.reload);
  assign half   = period >> 1;

  // software writes to the data address fill the transmit buffer
  assign buf_in_valid = bus_req.wr && (bus_req.addr == DATA_ADDR);

  two_entry_buffer #(
    .WIDTH (TXBUF_WIDTH),
    .DEPTH (TXBUF_DEPTH)
  ) u_txbuf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (tx_buf_ready),
    .in_data   ({ctrl_reg.tx_ninth_bit, bus_req.wdata}),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // pin synchroniser
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= rxd_in;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // register file; hardware sets win over software clears
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    rdata_next = 8'h00;
    if (bus_req.wr)
    begin
      case (bus_req.addr)
        SCON_ADDR:
        begin
          if (ctrl_reg.frame_error_access_select)
            ctrl_next.framing_error_flag = bus_req.wdata[SCON_HI]; // RL1
          else
            ctrl_next.mode_select_high = bus_req.wdata[SCON_HI]; // RL2
          ctrl_next.mode_select_low  = bus_req.wdata[SCON_LO];
          ctrl_next.multiproc_enable = bus_req.wdata[SCON_MP];
          ctrl_next.rx_enable        = bus_req.wdata[SCON_REN];
          ctrl_next.tx_ninth_bit     = bus_req.wdata[SCON_TB8];
          ctrl_next.rx_ninth_bit     = bus_req.wdata[SCON_RB8];
          ctrl_next.tx_done_flag     = bus_req.wdata[SCON_TI];
          ctrl_next.rx_done_flag     = bus_req.wdata[SCON_RI];
        end
        CFG_ADDR:
        begin
          ctrl_next.frame_error_access_select = bus_req.wdata[CFG_FSEL];
          ctrl_next.double_speed_option       = bus_req.wdata[CFG_DBL];
          ctrl_next.double_baud               = bus_req.wdata[CFG_SMOD];
        end
        RELOAD_ADDR: ctrl_next.reload = bus_req.wdata;
        default: ;
      endcase
    end
    if (ti_set)
      ctrl_next.tx_done_flag = 1'b1; // RL8
    if (ri_set)
      ctrl_next.rx_done_flag = 1'b1; // RL9
    if (fe_set)
      ctrl_next.framing_error_flag = 1'b1; // RL1
    if (rx_load)
    begin
      ctrl_next.rx_data      = rx_load_data;
      ctrl_next.rx_ninth_bit = rx_load_ninth; // RL7
    end
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        SCON_ADDR:
          rdata_next = {ctrl_reg.frame_error_access_select ? ctrl_reg.framing_error_flag
                                                           : ctrl_reg.mode_select_high, // RL2
                        ctrl_reg.mode_select_low, ctrl_reg.multiproc_enable,
                        ctrl_reg.rx_enable, ctrl_reg.tx_ninth_bit, ctrl_reg.rx_ninth_bit,
                        ctrl_reg.tx_done_flag, ctrl_reg.rx_done_flag};
        DATA_ADDR:   rdata_next = ctrl_reg.rx_data;
        CFG_ADDR:
        begin
          rdata_next[CFG_FSEL] = ctrl_reg.frame_error_access_select;
          rdata_next[CFG_DBL]  = ctrl_reg.double_speed_option;
          rdata_next[CFG_SMOD] = ctrl_reg.double_baud;
          rdata_next[CFG_FULL] = ~tx_buf_ready;
        end
        RELOAD_ADDR: rdata_next = ctrl_reg.reload;
        default:     rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_reg  <= '0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // transmitter; also drives the shift clock in mode 0
  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_cnt_next   = tx_cnt_reg - 16'h0001;
    tx_idx_next   = tx_idx_reg;
    tx_shift_next = tx_shift_reg;
    tx_line_next  = tx_line_reg;
    tx_oe_next    = tx_oe_reg;
    tx_data_next  = tx_data_reg;
    buf_pop       = 1'b0;
    ti_set        = 1'b0;
    case (tx_state_reg)
      T_IDLE:
      begin
        tx_line_next = 1'b1;
        tx_oe_next   = 1'b0;
        tx_cnt_next  = period - 16'h0001;
        tx_idx_next  = 3'h0;
        // mode 0 receive owns the data pin once started
        if (buf_out_valid && rx_state_reg != R_SHIFT)
        begin
          buf_pop       = 1'b1;
          tx_shift_next = buf_out_data; // RL6
          if (mode == MODE_SHIFT)
          begin
            tx_state_next = T_SHIFT;
            tx_oe_next    = 1'b1;
            tx_data_next  = buf_out_data[0];
            tx_line_next  = 1'b0;
          end
          else
          begin
            tx_state_next = T_START;
            tx_line_next  = 1'b0; // RL11
          end
        end
      end
      T_SHIFT:
      begin
        // clock low in first half, rises mid-bit for the far end to sample
        if (tx_cnt_reg == half)
          tx_line_next = 1'b1;
        if (tx_cnt_reg == 16'h0000)
        begin
          tx_cnt_next = period - 16'h0001;
          if (tx_idx_reg == 3'h7)
          begin
            ti_set        = 1'b1; // RL8
            tx_oe_next    = 1'b0;
            tx_state_next = T_IDLE;
          end
          else
          begin
            tx_idx_next   = tx_idx_reg + 3'h1;
            tx_shift_next = tx_shift_reg >> 1;
            tx_data_next  = tx_shift_reg[1];
            tx_line_next  = 1'b0;
          end
        end
      end
      T_START:
        if (tx_cnt_reg == 16'h0000)
        begin
          tx_cnt_next   = period - 16'h0001;
          tx_state_next = T_DATA;
          tx_line_next  = tx_shift_reg[0]; // RL11
        end
      T_DATA:
        if (tx_cnt_reg == 16'h0000)
        begin
          tx_cnt_next   = period - 16'h0001;
          tx_shift_next = tx_shift_reg >> 1;
          if (tx_idx_reg == 3'h7 && mode9)
          begin
            tx_state_next = T_NINTH;
            tx_line_next  = tx_shift_reg[1]; // RL6
          end
          else if (tx_idx_reg == 3'h7)
          begin
            tx_state_next = T_STOP;
            tx_line_next  = 1'b1; // RL11
            ti_set        = 1'b1; // RL8
          end
          else
          begin
            tx_idx_next  = tx_idx_reg + 3'h1;
            tx_line_next = tx_shift_reg[1]; // RL11
          end
        end
      T_NINTH:
        if (tx_cnt_reg == 16'h0000)
        begin
          tx_cnt_next   = period - 16'h0001;
          tx_state_next = T_STOP;
          tx_line_next  = 1'b1; // RL11
          ti_set        = 1'b1; // RL8
        end
      T_STOP:
        if (tx_cnt_reg == 16'h0000)
          tx_state_next = T_IDLE;
      default: tx_state_next = T_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_state_reg <= T_IDLE;
      tx_cnt_reg   <= 16'h0000;
      tx_idx_reg   <= 3'h0;
      tx_shift_reg <= 9'h000;
      tx_line_reg  <= 1'b1;
      tx_oe_reg    <= 1'b0;
      tx_data_reg  <= 1'b1;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_idx_reg   <= tx_idx_next;
      tx_shift_reg <= tx_shift_next;
      tx_line_reg  <= tx_line_next;
      tx_oe_reg    <= tx_oe_next;
      tx_data_reg  <= tx_data_next;
    end
  end

  // receiver
  always_comb
  begin
    rx_state_next = rx_state_reg;
    rx_cnt_next   = rx_cnt_reg - 16'h0001;
    rx_idx_next   = rx_idx_reg;
    rx_shift_next = rx_shift_reg;
    rx_sclk_next  = rx_sclk_reg;
    ri_set        = 1'b0;
    fe_set        = 1'b0;
    rx_load       = 1'b0;
    rx_load_data  = rx_shift_reg[8:1];
    rx_load_ninth = rx_sync_reg;
    case (rx_state_reg)
      R_IDLE:
      begin
        rx_sclk_next = 1'b1;
        rx_idx_next  = 3'h0;
        rx_cnt_next  = period - 16'h0001;
        if (ctrl_reg.rx_enable && mode == MODE_SHIFT && !ctrl_reg.rx_done_flag
            && tx_state_reg == T_IDLE && !buf_out_valid) // RL5
        begin
          rx_state_next = R_SHIFT;
          rx_sclk_next  = 1'b0;
        end
        else if (ctrl_reg.rx_enable && mode != MODE_SHIFT && rx_prev_reg
                 && !rx_sync_reg) // RL5
        begin
          rx_state_next = R_START;
          rx_cnt_next   = half - 16'h0001;
        end
      end
      R_SHIFT:
      begin
        if (rx_cnt_reg == half)
          rx_sclk_next = 1'b1;
        if (rx_cnt_reg == 16'h0000)
        begin
          rx_cnt_next   = period - 16'h0001;
          rx_shift_next = {rx_sync_reg, rx_shift_reg[8:1]};
          if (rx_idx_reg == 3'h7)
          begin
            rx_load       = 1'b1;
            rx_load_data  = {rx_sync_reg, rx_shift_reg[8:2]};
            rx_load_ninth = ctrl_reg.rx_ninth_bit;
            ri_set        = 1'b1; // RL9
            rx_state_next = R_IDLE;
          end
          else
          begin
            rx_idx_next  = rx_idx_reg + 3'h1;
            rx_sclk_next = 1'b0;
          end
        end
      end
      R_START:
        if (rx_cnt_reg == 16'h0000)
        begin
          rx_cnt_next = period - 16'h0001;
          // glitch shorter than half a bit is not a start
          rx_state_next = rx_sync_reg ? R_IDLE : R_DATA; // RL11
        end
      R_DATA:
        if (rx_cnt_reg == 16'h0000)
        begin
          rx_cnt_next   = period - 16'h0001;
          rx_shift_next = {rx_sync_reg, rx_shift_reg[8:1]};
          rx_idx_next   = rx_idx_reg + 3'h1;
          if (rx_idx_reg == 3'h7)
            rx_state_next = mode9 ? R_NINTH : R_STOP;
        end
      R_NINTH:
        if (rx_cnt_reg == 16'h0000)
        begin
          rx_cnt_next   = period - 16'h0001;
          rx_shift_next = {rx_sync_reg, rx_shift_reg[8:1]};
          rx_state_next = R_STOP;
        end
      R_STOP:
        if (rx_cnt_reg == 16'h0000)
        begin
          rx_state_next = R_IDLE;
          rx_load_data  = mode9 ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
          rx_load_ninth = mode9 ? rx_shift_reg[8] : rx_sync_reg; // RL7
          if (!rx_sync_reg)
            fe_set = 1'b1; // RL1
          // unread word is kept; address bit or stop bit qualifies under multiproc
          if (!ctrl_reg.rx_done_flag && (!ctrl_reg.multiproc_enable || rx_load_ninth)) // RL4
          begin
            rx_load = 1'b1;
            ri_set  = 1'b1; // RL9
          end
        end
      default: rx_state_next = R_IDLE;
    endcase
    if (!ctrl_reg.rx_enable)
    begin
      rx_state_next = R_IDLE; // RL5
      rx_sclk_next  = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_state_reg <= R_IDLE;
      rx_cnt_reg   <= 16'h0000;
      rx_idx_reg   <= 3'h0;
      rx_shift_reg <= 9'h000;
      rx_sclk_reg  <= 1'b1;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg   <= rx_cnt_next;
      rx_idx_reg   <= rx_idx_next;
      rx_shift_reg <= rx_shift_next;
      rx_sclk_reg  <= rx_sclk_next;
    end
  end

  // both clocks idle high, so the and merges the two mode 0 clocks
  assign txd_out  = tx_line_reg & rx_sclk_reg;
  assign rxd_out  = tx_data_reg;
  assign rxd_oe   = tx_oe_reg;
  assign rdata    = rdata_reg;
  assign uart_irq = ctrl_reg.tx_done_flag | ctrl_reg.rx_done_flag; // RL10

endmodule // second_uart

// *** second_uart_monitor.sv ***
// pin-level assertions for the second serial port
`timescale 1ns/1ps
module uart_monitor
  import second_uart_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // register port
  input wire bus_req_s   bus_req,
  input wire logic [7:0] rdata,
  // serial pins and status
  input wire logic       rxd_in,
  input wire logic       rxd_out,
  input wire logic       rxd_oe,
  input wire logic       txd_out,
  input wire logic       tx_buf_ready,
  input wire logic       uart_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  rdata_idle_a: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (bus_req.rd && (bus_req.addr < SCON_ADDR
    || bus_req.addr > RELOAD_ADDR) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_flags_a: assert property (
    bus_req.rd && bus_req.addr == SCON_ADDR |=> (|rdata[1:0]) == $past(uart_irq))
    else $error("irq differs from done flags");
  irq_hold_a: assert property (
    $fell(uart_irq) |-> $past(bus_req.wr && bus_req.addr == SCON_ADDR))
    else $error("irq dropped without software clear");
  full_flag_a: assert property (
    bus_req.rd && bus_req.addr == CFG_ADDR |=> rdata[CFG_FULL] == !$past(tx_buf_ready))
    else $error("full flag differs from ready");
  buf_fill_a: assert property (
    $fell(tx_buf_ready) |-> $past(bus_req.wr && bus_req.addr == DATA_ADDR))
    else $error("buffer filled without a write");
  reset_idle_a: assert property (
    $fell(rst) |-> txd_out && !rxd_oe && !uart_irq && tx_buf_ready)
    else $error("pins not idle after reset");
  start_len_a: assert property ($fell(txd_out) |-> !txd_out[*3])
    else $error("low phase shorter than three cycles");
endmodule // uart_monitor

bind second_uart uart_monitor u_uart_monitor (
  .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
  .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
  .tx_buf_ready(tx_buf_ready), .uart_irq(uart_irq));

// *** serial_station.sv ***
// remote serial station on the far side of the line
`timescale 1ns/1ps
module serial_station (
  // clock
  input wire logic core_clk,
  // serial line
  input wire logic line_in,
  output logic     line_out
);
  initial line_out = 1'b1;

  task send(input logic [8:0] d, input int n, input int p, input logic stop);
    line_out <= 1'b0;
    repeat (p) @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      line_out <= d[i];
      repeat (p) @(posedge core_clk);
    end
    line_out <= stop;
    repeat (p) @(posedge core_clk);
    // one idle cycle so back-to-back frames never drive twice in a step
    line_out <= 1'b1;
    @(posedge core_clk);
  endtask

  task recv(output logic [8:0] d, output logic stop, input int n, input int p);
    d = 9'h000;
    do @(negedge core_clk); while (line_in);
    repeat (p / 2) @(negedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      repeat (p) @(negedge core_clk);
      d[i] = line_in;
    end
    repeat (p) @(negedge core_clk);
    stop = line_in;
    // hand back just after a rising edge so bus tasks start where the master may move
    @(posedge core_clk);
  endtask
endmodule // serial_station

// *** second_uart_serial_control_bench.sv ***
// self-checking bench for the second serial port
`timescale 1ns/1ps
module second_uart_serial_control_bench
  import second_uart_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  bus_req_s   bus_req = '0;
  logic [7:0] rdata;
  logic       rxd_oe, rxd_out, txd_out, tx_buf_ready, uart_irq, line;
  int         mismatches = 0;
  int         comparisons = 0;
  int         cycles = 0;

  always #5 core_clk = ~core_clk;

  second_uart u_second_uart (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .rxd_in(rxd_oe ? rxd_out : line), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out), .tx_buf_ready(tx_buf_ready), .uart_irq(uart_irq));
  serial_station u_serial_station (
    .core_clk(core_clk), .line_in(txd_out), .line_out(line));

  task finish_test;
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task bw(input logic [7:0] a, input logic [7:0] d);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task br(input logic [7:0] a, input logic [7:0] e);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(negedge core_clk);
    chk(rdata, e);
    @(posedge core_clk);
  endtask

  task regs_reset;
    br(SCON_ADDR, SCON_RESET);
    br(CFG_ADDR, CFG_RESET);
    br(RELOAD_ADDR, RELOAD_RESET);
    br(8'hc7, 8'h00);
  endtask

  task shift_tx;
    logic [7:0] d;
    bw(DATA_ADDR, 8'h96);
    for (int i = 0; i < 8; i++)
    begin
      do @(negedge core_clk); while (txd_out);
      do @(negedge core_clk); while (!txd_out);
      d[i] = rxd_out;
      chk(rxd_oe, 1'b1);
    end
    repeat (12) @(posedge core_clk);
    chk(d, 8'h96);
    br(SCON_ADDR, 8'h02);
    bw(SCON_ADDR, 8'h00);
  endtask

  task async_tx;
    logic [8:0] d;
    logic       s;
    int         n;
    bw(CFG_ADDR, 8'h06);
    bw(SCON_ADDR, 8'h88);
    fork
      begin
        u_serial_station.recv(d, s, 9, 16);
        chk(d, 9'h1a5);
        chk(s, 1'b1);
        u_serial_station.recv(d, s, 9, 16);
        chk(d, 9'h13c);
        u_serial_station.recv(d, s, 9, 16);
        chk(d, 9'h15a);
      end
      begin
        n = 0;
        do begin @(negedge core_clk); n++; end while (!uart_irq && n < 400);
        chk(n >= 161 && n <= 166, 1'b1);
      end
      begin
        bw(DATA_ADDR, 8'ha5);
        bw(DATA_ADDR, 8'h3c);
        bw(DATA_ADDR, 8'h5a);
        @(negedge core_clk);
        chk(tx_buf_ready, 1'b0);
        @(posedge core_clk);
        bw(DATA_ADDR, 8'h99);
      end
    join
    br(SCON_ADDR, 8'h8a);
    bw(SCON_ADDR, 8'h88);
    @(negedge core_clk);
    chk(uart_irq, 1'b0);
    // a fourth frame would have set the done flag again
    repeat (300) @(posedge core_clk);
    br(SCON_ADDR, 8'h88);
  endtask

  task async_rx;
    bw(CFG_ADDR, 8'h02);
    bw(SCON_ADDR, 8'he0);
    u_serial_station.send(9'h144, 9, 8, 1'b1);
    br(SCON_ADDR, 8'he0);
    bw(SCON_ADDR, 8'hf0);
    u_serial_station.send(9'h011, 9, 8, 1'b1);
    br(SCON_ADDR, 8'hf0);
    u_serial_station.send(9'h122, 9, 8, 1'b1);
    br(SCON_ADDR, 8'hf5);
    br(DATA_ADDR, 8'h22);
    bw(CFG_ADDR, 8'h03);
    bw(SCON_ADDR, 8'h50);
    u_serial_station.send(9'h033, 9, 8, 1'b0);
    br(SCON_ADDR, 8'hd1);
    u_serial_station.send(9'h044, 9, 8, 1'b1);
    br(SCON_ADDR, 8'hd1);
    bw(SCON_ADDR, 8'h50);
    br(SCON_ADDR, 8'h50);
    bw(CFG_ADDR, 8'h02);
    br(SCON_ADDR, 8'hd0);
  endtask

  // mode 1 both ways at a reload-derived rate of 16 clocks per bit
  task mode1_link;
    logic [8:0] d;
    logic       s;
    bw(RELOAD_ADDR, 8'h01);
    bw(SCON_ADDR, 8'h50);
    u_serial_station.send(9'h0a7, 8, 16, 1'b1);
    br(SCON_ADDR, 8'h55);
    br(DATA_ADDR, 8'ha7);
    bw(DATA_ADDR, 8'h3c);
    u_serial_station.recv(d, s, 8, 16);
    chk(d, 9'h03c);
    chk(s, 1'b1);
    br(SCON_ADDR, 8'h57);
  endtask

  // mode 0 receive: idle line gives all ones, a held-low line all zeros
  task shift_rx;
    bw(SCON_ADDR, 8'h10);
    repeat (110) @(posedge core_clk);
    br(SCON_ADDR, 8'h11);
    br(DATA_ADDR, 8'hff);
    bw(SCON_ADDR, 8'h10);
    u_serial_station.send(9'h000, 9, 12, 1'b1);
    br(DATA_ADDR, 8'h00);
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test;
    end
  end

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    regs_reset;
    shift_tx;
    async_tx;
    async_rx;
    mode1_link;
    shift_rx;
    finish_test;
  end
endmodule // second_uart_serial_control_bench
